// ==== tb/frt_pin_model.sv ====
// Pin-side partner of the timer: a gated external clock source.
// Assumes the bench raises ext_en only while the external clock is wanted.
module frt_pin_model (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic ext_en,
  output logic ext_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Toggle spacing
  localparam int GAP = 5;
  logic [2:0] gap_reg;
  // One transition every GAP cycles; one above the legal minimum
  // to absorb synchroniser skew. Pin holds its level between bursts.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg <= 3'h0;
      ext_clock_pin <= 1'b0;
    end else if (!ext_en) begin
      gap_reg <= 3'h0;
    end else if (gap_reg == 3'(GAP - 1)) begin
      gap_reg <= 3'h0;
      ext_clock_pin <= ~ext_clock_pin;
    end else begin
      gap_reg <= gap_reg + 3'h1;
    end
  end
endmodule

// ==== tb/frt_timer_bench.sv ====
// Self-checking bench for the free-running timer with capture.
// Assumes the timer design, its header and the pin model are compiled.
`include "frt_timer_params.svh"
module frt_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic cpu_irq_mask = 1'b1;
  logic halt_mode = 1'b1;
  logic ext_en = 1'b0;
  logic ext_clock_pin;
  logic capture_pin1 = 1'b0;
  logic capture_pin2 = 1'b0;
  logic timer_irq;
  int failures = 0;
  int samples_checked = 0;
  logic [15:0] a;
  logic [15:0] b;
  logic [7:0] d;

  // ==========================================================
  // Design and partner
  frt_timer uut (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .cpu_irq_mask(cpu_irq_mask),
    .halt_mode(halt_mode),
    .ext_clock_pin(ext_clock_pin),
    .capture_pin1(capture_pin1),
    .capture_pin2(capture_pin2),
    .timer_irq(timer_irq)
  );
  frt_pin_model pins (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .ext_en(ext_en),
    .ext_clock_pin(ext_clock_pin)
  );

  // Clock at 25 ns
  always #12.5 ref_clk = ~ref_clk;

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Data is sampled 1 ns into the only cycle where it stands
  task automatic rd(input logic [3:0] ad, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rd16(input logic [3:0] hi, output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    rd(hi, h);
    rd(hi + 4'h1, l);
    v = {h, l};
  endtask
  // Counter runs exactly n cycles, or n+8 with the external clock, so tick counts are exact
  task automatic run(input int n, input logic ext);
    @(posedge ref_clk);
    halt_mode <= 1'b0;
    ext_en <= ext;
    repeat (n) @(posedge ref_clk);
    ext_en <= 1'b0;
    repeat (ext ? 8 : 0) @(posedge ref_clk);
    halt_mode <= 1'b1;
  endtask
  // Capture pins: settle through the synchronisers before looking
  task automatic pin(input logic [1:0] v);
    @(posedge ref_clk);
    {capture_pin2, capture_pin1} <= v;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic status(input logic [7:0] exp);
    rd(`FRT_OFF_STATUS, d);
    chk({8'h00, d & 8'hc0}, {8'h00, exp});
  endtask
  task automatic test_done;
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (5000) @(posedge ref_clk);
    failures++;
    test_done;
  end

  // ==========================================================
  // Test sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd16(`FRT_OFF_COUNT_HI, a);
    chk(a, 16'hfffc);
    rd16(`FRT_OFF_SHADOW_HI, a);
    chk(a, 16'hfffc);
    rd(4'hf, d);
    chk({8'h00, d}, 16'h0000);
    // Overflow, interrupt gating and two-step clear
    wr(`FRT_OFF_CTRL_ONE, 8'h20);
    run(20, 1'b0);
    rd(`FRT_OFF_STATUS, d);
    chk({8'h00, d}, 16'h0020);
    chk({15'h0000, timer_irq}, 16'h0000);
    @(posedge ref_clk) cpu_irq_mask <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk({15'h0000, timer_irq}, 16'h0001);
    rd(`FRT_OFF_SHADOW_LO, d);
    rd(`FRT_OFF_STATUS, d);
    chk({8'h00, d}, 16'h0020);
    rd16(`FRT_OFF_COUNT_HI, a);
    chk(a, 16'h0006);
    rd(`FRT_OFF_STATUS, d);
    chk({8'h00, d}, 16'h0000);
    chk({15'h0000, timer_irq}, 16'h0000);
    // Prescaler ratios, each from a forced reload
    for (int s = 0; s < 3; s++) begin
      wr(`FRT_OFF_CTRL_TWO, {4'h0, 2'(s), 2'b00});
      wr(s == 1 ? `FRT_OFF_SHADOW_LO : `FRT_OFF_COUNT_LO, 8'h00);
      rd16(`FRT_OFF_COUNT_HI, a);
      chk(a, 16'hfffc);
      run(64, 1'b0);
      rd16(`FRT_OFF_COUNT_HI, b);
      chk(b - a, 16'(64 >> (s + 1)));
    end
    // External clock: five toggles from low, then four from high
    wr(`FRT_OFF_CTRL_TWO, {4'h0, frt_pkg::FRT_EXT, 2'b01});
    rd16(`FRT_OFF_COUNT_HI, a);
    run(25, 1'b1);
    rd16(`FRT_OFF_COUNT_HI, b);
    chk(b - a, 16'h0003);
    wr(`FRT_OFF_CTRL_TWO, {4'h0, frt_pkg::FRT_EXT, 2'b00});
    rd16(`FRT_OFF_COUNT_HI, a);
    run(20, 1'b1);
    rd16(`FRT_OFF_COUNT_HI, b);
    chk(b - a, 16'h0002);
    // Buffered low byte across repeated high reads
    wr(`FRT_OFF_CTRL_TWO, 8'h00);
    wr(`FRT_OFF_COUNT_LO, 8'h00);
    rd(`FRT_OFF_COUNT_HI, d);
    chk({8'h00, d}, 16'h00ff);
    run(6, 1'b0);
    rd(`FRT_OFF_COUNT_HI, d);
    chk({8'h00, d}, 16'h00ff);
    rd(`FRT_OFF_COUNT_LO, d);
    chk({8'h00, d}, 16'h00fc);
    run(2, 1'b0);
    rd16(`FRT_OFF_SHADOW_HI, a);
    chk(a, 16'h0000);
    run(2, 1'b0);
    rd(`FRT_OFF_COUNT_LO, d);
    chk({8'h00, d}, 16'h0001);
    // Channel one capture, rising edge, interrupt enabled
    wr(`FRT_OFF_CTRL_ONE, 8'h82);
    pin(2'b01);
    status(8'h80);
    chk({15'h0000, timer_irq}, 16'h0001);
    rd16(`FRT_OFF_CAP1_HI, a);
    chk(a, 16'h0001);
    status(8'h00);
    chk({15'h0000, timer_irq}, 16'h0000);
    // Channel two on falling edges only
    pin(2'b11);
    status(8'h00);
    pin(2'b01);
    status(8'h40);
    rd(`FRT_OFF_CAP2_LO, d);
    status(8'h00);
    rd(`FRT_OFF_CAP2_HI, d);
    run(2, 1'b0);
    pin(2'b11);
    pin(2'b01);
    status(8'h00);
    rd(`FRT_OFF_CAP2_LO, d);
    chk({8'h00, d}, 16'h0001);
    pin(2'b11);
    pin(2'b01);
    rd16(`FRT_OFF_CAP2_HI, a);
    chk(a, 16'h0002);
    // One pulse mode leaves only channel two capturing
    rd(`FRT_OFF_STATUS, d);
    wr(`FRT_OFF_CTRL_TWO, 8'h10);
    pin(2'b00);
    pin(2'b11);
    pin(2'b00);
    status(8'h40);
    test_done;
  end
endmodule

// ==== verilog/frt_pkg.sv ====
// Types shared by the free-running timer design.
// Assumes nothing beyond a SystemVerilog compiler.
package frt_pkg;
  // ==========================================================
  // Timer clock source selection
  typedef enum logic [1:0] {
    FRT_DIV2 = 2'b00,
    FRT_DIV4 = 2'b01,
    FRT_DIV8 = 2'b10,
    FRT_EXT  = 2'b11
  } frt_clk_sel_t;
endpackage

// ==== verilog/frt_timer.sv ====
// 16-bit free-running timer with two input capture channels.
// Assumes a byte register port on ref_clk and asynchronous pins.
//
// Design decisions made here: the plain strobed port and the register offsets.
`include "frt_timer_params.svh"

module frt_timer (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_irq_mask,
  input wire logic halt_mode,
  input wire logic ext_clock_pin,
  input wire logic capture_pin1,
  input wire logic capture_pin2,
  output logic timer_irq
);
  // ==========================================================
  // Declarations
  logic [7:0] control_reg_one;
  logic [7:0] control_reg_two;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [2:0] presc_reg;
  logic [7:0] low_buf_reg;
  logic buf_valid_reg;
  logic overflow_flag;
  logic ovf_armed_reg;
  logic [1:0] capture_flag;
  logic [1:0] cap_armed_reg;
  logic [1:0] cap_lock_reg;
  logic [15:0] capture_value_one;
  logic [15:0] capture_value_two;
  logic [2:0] ext_sync_reg;
  logic [2:0] cap1_sync_reg;
  logic [2:0] cap2_sync_reg;
  logic irq_reg;
  logic tick;
  logic wrap;
  logic count_reload;
  logic main_lo_acc;
  logic [1:0] cap_lo_rd;
  logic [1:0] cap_hi_rd;
  logic [1:0] cap_hit;
  logic status_rd;
  logic pulse_mode;
  frt_pkg::frt_clk_sel_t clk_sel;

  // Active edge of a synchronised pin, rising when sel is one
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic sel);
    edge_hit = sel ? (cur & ~prev) : (prev & ~cur);
  endfunction

  // ==========================================================
  // Pin synchronisers: bit 0 is read only by bit 1
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_sync_reg <= 3'h0;
      cap1_sync_reg <= 3'h0;
      cap2_sync_reg <= 3'h0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_clock_pin};
      cap1_sync_reg <= {cap1_sync_reg[1:0], capture_pin1};
      cap2_sync_reg <= {cap2_sync_reg[1:0], capture_pin2};
    end
  end

  // ==========================================================
  // Access decode
  assign main_lo_acc = (reg_rd | reg_wr) && reg_addr == `FRT_OFF_COUNT_LO;
  assign count_reload = reg_wr && (reg_addr == `FRT_OFF_COUNT_LO ||
                        reg_addr == `FRT_OFF_SHADOW_LO);
  assign status_rd = reg_rd && reg_addr == `FRT_OFF_STATUS;
  assign cap_hi_rd = {reg_rd && reg_addr == `FRT_OFF_CAP2_HI,
                      reg_rd && reg_addr == `FRT_OFF_CAP1_HI};
  // Writes to capture low bytes count as accesses for flag clearing
  assign cap_lo_rd = {(reg_rd | reg_wr) && reg_addr == `FRT_OFF_CAP2_LO,
                      (reg_rd | reg_wr) && reg_addr == `FRT_OFF_CAP1_LO};
  assign clk_sel = frt_pkg::frt_clk_sel_t'(
    control_reg_two[`FRT_C2_CLK_HI:`FRT_C2_CLK_LO]);
  assign pulse_mode = control_reg_two[`FRT_C2_ONEPULSE] |
                      control_reg_two[`FRT_C2_PWIDTH];

  // ==========================================================
  // Control registers, plain read/write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      control_reg_one <= `FRT_BYTE_ZERO;
      control_reg_two <= `FRT_BYTE_ZERO;
    end else if (reg_wr) begin
      if (reg_addr == `FRT_OFF_CTRL_ONE) begin
        control_reg_one <= reg_wdata;
      end
      if (reg_addr == `FRT_OFF_CTRL_TWO) begin
        control_reg_two <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Tick generation; ref_clk is the CPU clock, so every update sits
  // on one CPU clock edge even for the external source
  always_comb begin
    tick = 1'b0;
    case (clk_sel)
      frt_pkg::FRT_DIV2: tick = presc_reg[0];
      frt_pkg::FRT_DIV4: tick = &presc_reg[1:0];
      frt_pkg::FRT_DIV8: tick = &presc_reg;
      frt_pkg::FRT_EXT: tick = edge_hit(ext_sync_reg[2], ext_sync_reg[1],
                            control_reg_two[`FRT_C2_EXT_EDG]);
      default: tick = 1'b0;
    endcase
    if (halt_mode) begin
      tick = 1'b0;
    end
  end

  // Prescaler; halt freezes it with the counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_reg <= 3'h0;
    end else if (count_reload) begin
      presc_reg <= 3'h0;
    end else if (!halt_mode) begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  // ==========================================================
  // Free-running counter; external edges closer than four clocks
  // are still counted but may be missed by the synchroniser
  assign wrap = tick && count_reg == `FRT_COUNT_MAX;
  always_comb begin
    count_next = count_reg;
    if (count_reload) begin
      count_next = `FRT_COUNT_RESET;
    end else if (tick) begin
      count_next = count_reg + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= `FRT_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  // ==========================================================
  // Low-byte buffer shared by both views
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_buf_reg <= `FRT_BYTE_ZERO;
      buf_valid_reg <= 1'b0;
    end else if (reg_rd) begin
      if (reg_addr == `FRT_OFF_COUNT_HI ||
          reg_addr == `FRT_OFF_SHADOW_HI) begin
        if (!buf_valid_reg) begin
          low_buf_reg <= count_reg[7:0];
        end
        buf_valid_reg <= 1'b1;
      end else if (reg_addr == `FRT_OFF_COUNT_LO ||
                   reg_addr == `FRT_OFF_SHADOW_LO) begin
        buf_valid_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Overflow flag; a wrap in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else begin
      if (wrap && !count_reload) begin
        overflow_flag <= 1'b1;
      end else if (main_lo_acc && ovf_armed_reg) begin
        overflow_flag <= 1'b0;
      end
      if (status_rd && overflow_flag) begin
        ovf_armed_reg <= 1'b1;
      end else if (main_lo_acc) begin
        ovf_armed_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Capture triggers; channel one is blocked in either pulse mode, channel two never
  assign cap_hit[0] = edge_hit(cap1_sync_reg[2], cap1_sync_reg[1],
                        control_reg_one[`FRT_C1_CAP1_EDG]) &&
                      !cap_lock_reg[0] && !pulse_mode;
  assign cap_hit[1] = edge_hit(cap2_sync_reg[2], cap2_sync_reg[1],
                        control_reg_two[`FRT_C2_CAP2_EDG]) &&
                      !cap_lock_reg[1];

  // Capture values have no defined reset; zero keeps them known
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_value_one <= 16'h0000;
      capture_value_two <= 16'h0000;
    end else begin
      if (cap_hit[0]) begin
        capture_value_one <= count_reg;
      end
      if (cap_hit[1]) begin
        capture_value_two <= count_reg;
      end
    end
  end

  // Flags, clearing arm and high-read lock per channel
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      capture_flag <= 2'h0;
      cap_armed_reg <= 2'h0;
      cap_lock_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cap_hit[i]) begin
          capture_flag[i] <= 1'b1;
        end else if (cap_lo_rd[i] && cap_armed_reg[i]) begin
          capture_flag[i] <= 1'b0;
        end
        if (status_rd && capture_flag[i]) begin
          cap_armed_reg[i] <= 1'b1;
        end else if (cap_lo_rd[i]) begin
          cap_armed_reg[i] <= 1'b0;
        end
        if (cap_hi_rd[i]) begin
          cap_lock_reg[i] <= 1'b1;
        end else if (cap_lo_rd[i] && reg_rd) begin
          cap_lock_reg[i] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Interrupt request; flags hold, so the request stays pending
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= !cpu_irq_mask &&
        ((overflow_flag && control_reg_one[`FRT_C1_OVF_IE]) ||
         ((|capture_flag) && control_reg_one[`FRT_C1_CAP_IE]));
    end
  end
  assign timer_irq = irq_reg;

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `FRT_BYTE_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `FRT_OFF_CTRL_ONE: reg_rdata <= control_reg_one;
        `FRT_OFF_CTRL_TWO: reg_rdata <= control_reg_two;
        `FRT_OFF_STATUS: reg_rdata <= {capture_flag[0], capture_flag[1],
                                       overflow_flag, 5'h00};
        `FRT_OFF_CAP1_HI: reg_rdata <= capture_value_one[15:8];
        `FRT_OFF_CAP1_LO: reg_rdata <= capture_value_one[7:0];
        `FRT_OFF_CAP2_HI: reg_rdata <= capture_value_two[15:8];
        `FRT_OFF_CAP2_LO: reg_rdata <= capture_value_two[7:0];
        `FRT_OFF_COUNT_HI, `FRT_OFF_SHADOW_HI: begin
          reg_rdata <= count_reg[15:8];
        end
        `FRT_OFF_COUNT_LO, `FRT_OFF_SHADOW_LO: begin
          reg_rdata <= buf_valid_reg ? low_buf_reg
                                     : count_reg[7:0];
        end
        default: reg_rdata <= `FRT_BYTE_ZERO;
      endcase
    end else begin
      reg_rdata <= `FRT_BYTE_ZERO;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_reload;
    count_reload |=> count_reg == `FRT_COUNT_RESET;
  endproperty
  a_reload: assert property (p_reload) else $error("reload missed");

  property p_step;
    tick && !count_reload |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("bad count step");

  property p_ovf_set;
    wrap && !count_reload |=> overflow_flag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("no ovf flag");

  property p_ovf_clr;
    $fell(overflow_flag) |-> $past(main_lo_acc && ovf_armed_reg);
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("bad ovf clr");

  property p_buf_hold;
    buf_valid_reg && reg_rd |=> $stable(low_buf_reg);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buf moved");

  property p_halt;
    halt_mode && !count_reload |=> $stable(count_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("halt counted");

  property p_cap;
    cap_hit[1] |=> capture_value_two == $past(count_reg) && capture_flag[1];
  endproperty
  a_cap: assert property (p_cap) else $error("capture lost");

  property p_lock;
    cap_lock_reg[0] |=> $stable(capture_value_one);
  endproperty
  a_lock: assert property (p_lock) else $error("locked capture");

  property p_pulse;
    pulse_mode |=> $stable(capture_value_one);
  endproperty
  a_pulse: assert property (p_pulse) else $error("ch1 in pulse");

  property p_irq;
    overflow_flag && control_reg_one[`FRT_C1_OVF_IE] && !cpu_irq_mask
      |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no ovf irq");

  c_wrap: cover property (wrap ##[1:4] overflow_flag);
  c_pair: cover property (reg_rd && reg_addr == `FRT_OFF_COUNT_HI
                          ##[1:8] reg_rd && reg_addr == `FRT_OFF_COUNT_LO);
  c_cap: cover property (cap_hit[0] ##[1:8] timer_irq);
endmodule

// ==== verilog/frt_timer_params.svh ====
// Constants of the free-running timer: offsets, fields, reset values.
// Assumes inclusion by bare name from the timer design and its bench.
`ifndef FRT_TIMER_PARAMS_SVH
`define FRT_TIMER_PARAMS_SVH

// ==========================================================
// Register offsets (byte registers, 4-bit address)
`define FRT_OFF_CTRL_ONE  4'h0
`define FRT_OFF_CTRL_TWO  4'h1
`define FRT_OFF_STATUS    4'h2
`define FRT_OFF_CAP1_HI   4'h3
`define FRT_OFF_CAP1_LO   4'h4
`define FRT_OFF_COUNT_HI  4'h5
`define FRT_OFF_COUNT_LO  4'h6
`define FRT_OFF_SHADOW_HI 4'h7
`define FRT_OFF_SHADOW_LO 4'h8
`define FRT_OFF_CAP2_HI   4'h9
`define FRT_OFF_CAP2_LO   4'hA

// ==========================================================
// Control register one fields
`define FRT_C1_CAP_IE   7
`define FRT_C1_OVF_IE   5
`define FRT_C1_CAP1_EDG 1
// Control register two fields
`define FRT_C2_PWIDTH   5
`define FRT_C2_ONEPULSE 4
`define FRT_C2_CLK_HI   3
`define FRT_C2_CLK_LO   2
`define FRT_C2_CAP2_EDG 1
`define FRT_C2_EXT_EDG  0
// Status register fields
`define FRT_SR_CAP1 7
`define FRT_SR_CAP2 6
`define FRT_SR_OVF  5

// ==========================================================
// Reset and wrap values
`define FRT_COUNT_RESET 16'hFFFC
`define FRT_COUNT_MAX   16'hFFFF
`define FRT_BYTE_ZERO   8'h00

`endif
